// >>> design/cto_timing_override.sv
// port-1 data-lane trail, exit and lane-skew timing override bank, apb slave
// Operation
// R1: trail timing is automatic unless its override bit is set; resets to 0x8
// R2: exit timing uses stored field only while override is set; resets to 0x0B
// R3: lane-skew parameter uses stored field only while override set; resets 0x6
// R4: with override clear the field is read-only and reads the automatic value
// R5: with override set the field accepts writes and reads back stored value
// R6: defaults match 800 Mbps; automatic values follow the selected lane rate
// R7: read-to-clear field is read-only and clears after each read
// R8: latched-low field captures a low, holds it until read, read-only
// R9: self-clearing field is writable and returns to zero after its action
// R10: value writes while override is clear are ignored
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module cto_timing_override (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        linkReady,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [6:0]  trailTiming,
  output logic      [6:0]  exitTiming,
  output logic      [6:0]  laneSkewTiming,
  output logic      [1:0]  laneRate
);
  import cto_pkg::*;

  // ==========================================================
  // bus decode
  cto_bus_t   busState;
  cto_bus_t   next_busState;
  logic [7:0] regIndex;
  logic       accessDone;
  logic       wrAccess;
  logic       rdAccess;
  logic       aligned;
  logic       knownIndex;
  logic       mapped;

  // ==========================================================
  // per-register strobes
  logic       trailWrite;
  logic       exitWrite;
  logic       skewWrite;
  logic       controlWrite;
  logic       statusRead;
  logic       eventsRead;

  // ==========================================================
  // control, status and event state
  logic       reloadPending;
  logic       linkOk;
  logic [7:0] rateChanges;
  logic       rateWrite;
  logic [1:0] newRate;

  // ==========================================================
  // timing field views and read path
  logic [7:0] trailRead;
  logic [7:0] exitRead;
  logic [7:0] skewRead;
  logic [6:0] trailAuto;
  logic [6:0] exitAuto;
  logic [6:0] skewAuto;
  logic [7:0] readMux;

  // transfer qualifiers; side effects land on the edge that sees pready
  assign regIndex   = paddr[ADDR_LSB +: 8];
  assign accessDone = psel && penable && pready;
  assign wrAccess   = accessDone && pwrite && mapped;
  assign rdAccess   = accessDone && !pwrite && mapped;
  assign newRate    = pwdata[RATE_MSB:RATE_LSB];

  // one strobe per register so each process tests a single name
  assign trailWrite   = wrAccess && (regIndex == IDX_TRAIL);
  assign exitWrite    = wrAccess && (regIndex == IDX_EXIT);
  assign skewWrite    = wrAccess && (regIndex == IDX_SKEW);
  assign controlWrite = wrAccess && (regIndex == IDX_CONTROL);
  assign statusRead   = rdAccess && (regIndex == IDX_STATUS);
  assign eventsRead   = rdAccess && (regIndex == IDX_EVENTS);

  // a rate write only counts as an event when the code really changes
  assign rateWrite    = controlWrite && (newRate != laneRate);

  // address decode: word aligned, inside the index range, and a known register
  always_comb begin
    aligned = (paddr[ADDR_LSB-1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    case (regIndex)
      IDX_TRAIL, IDX_EXIT, IDX_SKEW, IDX_CONTROL, IDX_STATUS, IDX_EVENTS: begin
        knownIndex = 1'b1;
      end
      default: begin
        knownIndex = 1'b0;
      end
    endcase
    mapped = aligned && knownIndex;
  end

  // answer sequencing: one wait state, then pready for one edge
  always_comb begin
    case (busState)
      BUS_IDLE: begin
        next_busState = (psel && penable) ? BUS_DONE : BUS_IDLE;
      end
      BUS_DONE: begin
        next_busState = BUS_IDLE;
      end
      default: begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState <= BUS_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  // ready pulses for one edge, one cycle into the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= (next_busState == BUS_DONE);
    end
  end

  // error rides with ready for an unmapped or misaligned address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= (next_busState == BUS_DONE) && !mapped;
    end
  end

  // ==========================================================
  // lane rate and automatic timing selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laneRate <= RATE_RESET;
    end else if (controlWrite) begin
      laneRate <= newRate; // R6
    end
  end

  // automatic trail value for the selected rate
  always_comb begin
    case (laneRate) // R6
      RATE_SEL_400: begin
        trailAuto = TRAIL_AUTO_400;
      end
      RATE_SEL_1200: begin
        trailAuto = TRAIL_AUTO_1200;
      end
      RATE_SEL_1600: begin
        trailAuto = TRAIL_AUTO_1600;
      end
      default: begin
        trailAuto = TRAIL_AUTO_800;
      end
    endcase
  end

  // automatic exit value for the selected rate
  always_comb begin
    case (laneRate) // R6
      RATE_SEL_400: begin
        exitAuto = EXIT_AUTO_400;
      end
      RATE_SEL_1200: begin
        exitAuto = EXIT_AUTO_1200;
      end
      RATE_SEL_1600: begin
        exitAuto = EXIT_AUTO_1600;
      end
      default: begin
        exitAuto = EXIT_AUTO_800;
      end
    endcase
  end

  // automatic lane-skew value for the selected rate
  always_comb begin
    case (laneRate) // R6
      RATE_SEL_400: begin
        skewAuto = SKEW_AUTO_400;
      end
      RATE_SEL_1200: begin
        skewAuto = SKEW_AUTO_1200;
      end
      RATE_SEL_1600: begin
        skewAuto = SKEW_AUTO_1600;
      end
      default: begin
        skewAuto = SKEW_AUTO_800;
      end
    endcase
  end

  // ==========================================================
  // self-clearing reload bit: clears all overrides, then drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reloadPending <= 1'b0;
    end else if (reloadPending) begin
      reloadPending <= 1'b0; // R9
    end else if (controlWrite) begin
      reloadPending <= pwdata[RELOAD_BIT]; // R9
    end
  end

  // latched-low link status: a low sticks until read, low beats the read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkOk <= 1'b0;
    end else if (!linkReady) begin
      linkOk <= 1'b0; // R8
    end else if (statusRead) begin
      linkOk <= 1'b1; // R8
    end
  end

  // read-to-clear count of rate changes; a new change beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rateChanges <= 8'h00;
    end else if (rateWrite) begin
      if (eventsRead) begin
        rateChanges <= 8'h01; // R7
      end else if (rateChanges != 8'hFF) begin
        rateChanges <= rateChanges + 8'h01;
      end
    end else if (eventsRead) begin
      rateChanges <= 8'h00; // R7
    end
  end

  // ==========================================================
  // the three timing registers
  cto_timing_field #(.RESET_VALUE(TRAIL_RESET)) uTrail (
    .clk         (clk),
    .rst_n       (rst_n),
    .autoValue   (trailAuto),
    .wrEn        (trailWrite), // R1
    .wrData      (pwdata[7:0]),
    .reloadAuto  (reloadPending),
    .readValue   (trailRead),
    .timingValue (trailTiming)
  );

  cto_timing_field #(.RESET_VALUE(EXIT_RESET)) uExit (
    .clk         (clk),
    .rst_n       (rst_n),
    .autoValue   (exitAuto),
    .wrEn        (exitWrite), // R2
    .wrData      (pwdata[7:0]),
    .reloadAuto  (reloadPending),
    .readValue   (exitRead),
    .timingValue (exitTiming)
  );

  cto_timing_field #(.RESET_VALUE(SKEW_RESET)) uSkew (
    .clk         (clk),
    .rst_n       (rst_n),
    .autoValue   (skewAuto),
    .wrEn        (skewWrite), // R3
    .wrData      (pwdata[7:0]),
    .reloadAuto  (reloadPending),
    .readValue   (skewRead),
    .timingValue (laneSkewTiming)
  );

  // ==========================================================
  // read data, captured as pready rises
  always_comb begin
    case (regIndex)
      IDX_TRAIL: begin
        readMux = trailRead; // R4
      end
      IDX_EXIT: begin
        readMux = exitRead;
      end
      IDX_SKEW: begin
        readMux = skewRead;
      end
      IDX_CONTROL: begin
        readMux = {reloadPending, 5'h00, laneRate};
      end
      IDX_STATUS: begin
        readMux = {7'h00, linkOk};
      end
      IDX_EVENTS: begin
        readMux = rateChanges;
      end
      default: begin
        readMux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if ((next_busState == BUS_DONE) && mapped && !pwrite) begin
      prdata <= {24'h000000, readMux};
    end else if (next_busState == BUS_DONE) begin
      prdata <= 32'h00000000; // writes and refused reads return zero
    end
  end
endmodule : cto_timing_override

// >>> design/cto_pkg.sv
// constants for the port-1 high-speed timing override register bank
package cto_pkg;
  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_TRAIL   = 8'h66;
  localparam logic [7:0] IDX_EXIT    = 8'h67;
  localparam logic [7:0] IDX_SKEW    = 8'h68;
  localparam logic [7:0] IDX_CONTROL = 8'h70;
  localparam logic [7:0] IDX_STATUS  = 8'h71;
  localparam logic [7:0] IDX_EVENTS  = 8'h72;
  localparam int         ADDR_LSB    = 2;

  // ==========================================================
  // field positions
  localparam int OVR_BIT      = 7;
  localparam int VAL_MSB      = 6;
  localparam int RATE_LSB     = 0;
  localparam int RATE_MSB     = 1;
  localparam int RELOAD_BIT   = 7;
  localparam int LINK_OK_BIT  = 0;

  // ==========================================================
  // lane rate codes; reset code selects 800 Mbps
  localparam logic [1:0] RATE_SEL_400  = 2'h0;
  localparam logic [1:0] RATE_SEL_800  = 2'h1;
  localparam logic [1:0] RATE_SEL_1200 = 2'h2;
  localparam logic [1:0] RATE_SEL_1600 = 2'h3;
  localparam logic [1:0] RATE_RESET    = RATE_SEL_800;

  // ==========================================================
  // reset values of the stored timing fields
  localparam logic [6:0] TRAIL_RESET = 7'h08;
  localparam logic [6:0] EXIT_RESET  = 7'h0B;
  localparam logic [6:0] SKEW_RESET  = 7'h06;

  // ==========================================================
  // automatic timing values per lane rate
  localparam logic [6:0] TRAIL_AUTO_400  = 7'h05;
  localparam logic [6:0] TRAIL_AUTO_800  = TRAIL_RESET;
  localparam logic [6:0] TRAIL_AUTO_1200 = 7'h0B;
  localparam logic [6:0] TRAIL_AUTO_1600 = 7'h0E;
  localparam logic [6:0] EXIT_AUTO_400   = 7'h06;
  localparam logic [6:0] EXIT_AUTO_800   = EXIT_RESET;
  localparam logic [6:0] EXIT_AUTO_1200  = 7'h10;
  localparam logic [6:0] EXIT_AUTO_1600  = 7'h15;
  localparam logic [6:0] SKEW_AUTO_400   = 7'h04;
  localparam logic [6:0] SKEW_AUTO_800   = SKEW_RESET;
  localparam logic [6:0] SKEW_AUTO_1200  = 7'h08;
  localparam logic [6:0] SKEW_AUTO_1600  = 7'h0A;

  // ==========================================================
  // bus answer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } cto_bus_t;
endpackage : cto_pkg

// >>> design/cto_timing_field.sv
// one override-capable seven-bit timing register
`timescale 1ns/1ps
module cto_timing_field #(
  parameter logic [6:0] RESET_VALUE = 7'h00
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] autoValue,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  input  wire logic       reloadAuto,
  output logic      [7:0] readValue,
  output logic      [6:0] timingValue
);
  import cto_pkg::*;

  logic       overrideOn;
  logic [6:0] storedValue;

  // override bit; a reload request hands control back to the automatic logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrideOn <= 1'b0;
    end else if (reloadAuto) begin
      overrideOn <= 1'b0;
    end else if (wrEn) begin
      overrideOn <= wrData[OVR_BIT];
    end
  end

  // stored value only writable while override is already on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      storedValue <= RESET_VALUE;
    end else if (wrEn && overrideOn) begin
      storedValue <= wrData[VAL_MSB:0]; // R5
    end else if (wrEn && wrData[OVR_BIT]) begin
      storedValue <= autoValue; // R10
    end
  end

  // read view: auto value while clear, stored value while set
  assign readValue = {overrideOn, overrideOn ? storedValue : autoValue}; // R4 R5

  // value handed to the transmitter timing logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timingValue <= RESET_VALUE;
    end else begin
      timingValue <= overrideOn ? storedValue : autoValue; // R1 R2 R3
    end
  end
endmodule : cto_timing_field

// >>> tb/cto_timing_override_sva.sv
// assertion checker for the port-1 timing override bank
`timescale 1ns/1ps
module cto_timing_override_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        linkReady,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [6:0]  trailTiming,
  input wire logic [6:0]  exitTiming,
  input wire logic [6:0]  laneSkewTiming,
  input wire logic [1:0]  laneRate
);
  import cto_pkg::*;
  // ==========
  // clocking, auto lookup and read completions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  function automatic logic [6:0] trailAuto(input logic [1:0] rate);
    logic [6:0] tab [4] = '{TRAIL_AUTO_400, TRAIL_AUTO_800, TRAIL_AUTO_1200, TRAIL_AUTO_1600};
    return tab[rate];
  endfunction : trailAuto
  sequence readDone(logic [7:0] idx);
    pready && !pwrite && paddr[9:2] == idx;
  endsequence
  // ==========
  // bus answer and timing relations
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  ready_delay_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access phase not two cycles");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  trail_auto_a: assert property (
    readDone(IDX_TRAIL) |-> prdata[OVR_BIT] || trailTiming == trailAuto(laneRate))
    else $error("trail output not automatic");
  read_auto_a: assert property (
    readDone(IDX_TRAIL) |-> prdata[OVR_BIT] || prdata[6:0] == trailAuto(laneRate))
    else $error("trail read not automatic value");
  trail_stored_a: assert property (
    readDone(IDX_TRAIL) |-> !prdata[OVR_BIT] || prdata[6:0] == trailTiming)
    else $error("trail output differs from stored");
  exit_stored_a: assert property (
    readDone(IDX_EXIT) |-> !prdata[OVR_BIT] || prdata[6:0] == exitTiming)
    else $error("exit output differs from stored");
  skew_stored_a: assert property (
    readDone(IDX_SKEW) |-> !prdata[OVR_BIT] || prdata[6:0] == laneSkewTiming)
    else $error("skew output differs from stored");
  timing_hold_a: assert property ($changed(trailTiming) |->
    $past(pready && pwrite, 1) || $past(pready && pwrite, 2) || $past(pready && pwrite, 3))
    else $error("trail output moved without a write");
endmodule : cto_timing_override_chk

bind cto_timing_override cto_timing_override_chk chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .linkReady(linkReady),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .trailTiming(trailTiming),
  .exitTiming(exitTiming), .laneSkewTiming(laneSkewTiming), .laneRate(laneRate));

// >>> tb/cto_timing_override_bench.sv
// self-checking bench for the port-1 timing override bank
`timescale 1ns/1ps
module cto_timing_override_bench;
  import cto_pkg::*;
  // ==========
  // stimulus, design and bookkeeping
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic        linkReady = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  trailTiming;
  logic [6:0]  exitTiming;
  logic [6:0]  laneSkewTiming;
  logic [1:0]  laneRate;
  logic [31:0] rd;
  logic        err;
  int          n_errors  = 0;
  int          compares  = 0;
  cto_timing_override uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .linkReady(linkReady), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trailTiming(trailTiming), .exitTiming(exitTiming),
    .laneSkewTiming(laneSkewTiming), .laneRate(laneRate));
  // 250 MHz clock
  always #2 clk = ~clk;
  // ==========
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : apb
  task automatic rdCk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask : rdCk
  // ==========
  // scenarios
  task automatic tReset;
    rdCk(IDX_TRAIL, 32'h08);
    rdCk(IDX_EXIT, 32'h0B);
    rdCk(IDX_SKEW, 32'h06);
    check({30'h0, laneRate}, {30'h0, RATE_SEL_800});
  endtask : tReset
  task automatic tRates;
    logic [6:0] tr [4] = '{TRAIL_AUTO_400, TRAIL_AUTO_800, TRAIL_AUTO_1200, TRAIL_AUTO_1600};
    logic [6:0] ex [4] = '{EXIT_AUTO_400, EXIT_AUTO_800, EXIT_AUTO_1200, EXIT_AUTO_1600};
    logic [6:0] sk [4] = '{SKEW_AUTO_400, SKEW_AUTO_800, SKEW_AUTO_1200, SKEW_AUTO_1600};
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, IDX_CONTROL, 8'(r));
      rdCk(IDX_TRAIL, {25'h0, tr[r]});
      rdCk(IDX_EXIT, {25'h0, ex[r]});
      rdCk(IDX_SKEW, {25'h0, sk[r]});
      check({25'h0, laneSkewTiming}, {25'h0, sk[r]});
    end
    rdCk(IDX_EVENTS, 32'h04);
    rdCk(IDX_EVENTS, 32'h00);
  endtask : tRates
  task automatic tOverride;
    apb(1'b1, IDX_TRAIL, 8'h05);
    rdCk(IDX_TRAIL, {25'h0, TRAIL_AUTO_1600});
    apb(1'b1, IDX_TRAIL, 8'h80);
    rdCk(IDX_TRAIL, {24'h0, 1'b1, TRAIL_AUTO_1600});
    apb(1'b1, IDX_TRAIL, 8'hD5);
    check({25'h0, trailTiming}, 32'h55);
    apb(1'b1, IDX_EXIT, 8'h80);
    apb(1'b1, IDX_EXIT, 8'hA2);
    apb(1'b1, IDX_SKEW, 8'h80);
    apb(1'b1, IDX_SKEW, 8'hFF);
    apb(1'b1, IDX_CONTROL, 8'h00);
    rdCk(IDX_TRAIL, 32'hD5);
    rdCk(IDX_EXIT, 32'hA2);
    rdCk(IDX_SKEW, 32'hFF);
    check({25'h0, exitTiming}, 32'h22);
    check({25'h0, laneSkewTiming}, 32'h7F);
  endtask : tOverride
  task automatic tReload;
    apb(1'b1, IDX_CONTROL, 8'h81);
    rdCk(IDX_CONTROL, 32'h01);
    rdCk(IDX_TRAIL, {25'h0, TRAIL_AUTO_800});
    check({25'h0, exitTiming}, {25'h0, EXIT_AUTO_800});
    rdCk(IDX_EVENTS, 32'h02);
    check({31'h0, err}, 32'h0);
    apb(1'b1, 8'h69, 8'h85);
    check({31'h0, err}, 32'h1);
  endtask : tReload
  task automatic tLink;
    rdCk(IDX_STATUS, 32'h00);
    rdCk(IDX_STATUS, 32'h01);
    linkReady <= 1'b0;
    @(posedge clk);
    linkReady <= 1'b1;
    rdCk(IDX_STATUS, 32'h00);
    rdCk(IDX_STATUS, 32'h01);
  endtask : tLink
  // ==========
  // verdict and run control
  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // watchdog cuts a hung handshake short
  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
  // reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tReset();
    tRates();
    tOverride();
    tReload();
    tLink();
    wrap_up();
  end
endmodule : cto_timing_override_bench
